// ==== design/can_fault_mbox.sv ====
// Fault confinement, mailbox flags and AXI4-Lite register file of the CAN controller
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module can_fault_mbox (
  input wire logic ref_clk_i, // 40 MHz module clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic can_rx_i, // Bus receive pin from transceiver
  input wire logic bit_tick_i, // Bit time strobe from bit timing
  input wire logic tx_err_i, // Transmit error seen, pulse
  input wire logic rx_err_i, // Receive error seen, pulse
  input wire logic tx_done_i, // Successful transmission, pulse
  input wire logic [2:0] tx_mbx_i, // Mailbox of the transmission
  input wire logic rx_done_i, // Successful reception, pulse
  input wire logic [2:0] rx_mbx_i, // Mailbox of the reception
  output logic [5:0] tx_req_o, // Mailboxes asking to transmit
  output logic [5:0] mbx_active_o, // Mailboxes taking part in traffic
  output logic [1:0] mbx_dir_o, // Direction of mailboxes 2 and 3
  output logic data_lock_o, // Change data request held
  output logic byte_order_o, // Data byte order select
  output logic bus_on_o, // Node may drive the bus
  output can_fc_pkg::err_state_t err_state_o, // Fault confinement state
  output logic irq_o // Interrupt, high while unmasked flag set
);
  import can_fc_pkg::*;

  // Decode a mailbox number into a one-hot vector
  function automatic logic [5:0] mbx_hot(input logic [2:0] idx);
    logic [5:0] v;
    v = 6'h00;
    if (idx < 3'h6) v[idx] = 1'b1;
    return v;
  endfunction : mbx_hot

  // Apply the two low byte strobes to write data
  function automatic logic [15:0] strobe16(input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : 8'h00, s[0] ? d[7:0] : 8'h00};
  endfunction : strobe16

  // Index is one of the mapped registers
  function automatic logic idx_known(input logic [5:0] i);
    return (i == IDX_MBX_DIR_EN) || (i == IDX_TX_CTRL) || (i == IDX_RX_CTRL) ||
           (i == IDX_MASTER_CTRL) || (i == IDX_ERR_STATUS) || (i == IDX_ERR_COUNT) ||
           (i == IDX_INT_FLAG) || (i == IDX_INT_MASK);
  endfunction : idx_known

  logic rx_meta_r;
  logic rx_sync_r;
  err_state_t state_r;
  err_state_t state_nxt;
  logic [8:0] tec_r;
  logic [8:0] tec_nxt;
  logic [7:0] rec_r;
  logic [7:0] rec_nxt;
  logic [15:0] mcr_r;
  logic [15:0] mcr_nxt;
  logic [7:0] mder_r;
  logic [5:0] trs_r;
  logic [5:0] trs_nxt;
  logic [5:0] ack_r;
  logic [5:0] ack_nxt;
  logic [5:0] rmp_r;
  logic [5:0] rmp_nxt;
  logic [15:0] ifr_r;
  logic [15:0] ifr_nxt;
  logic [15:0] imr_r;
  logic warn_r;
  logic passive_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // Bus pin synchroniser, first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= can_rx_i;
      rx_sync_r <= rx_meta_r;
    end
  end

  // AXI handshakes: write takes address and data together
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire rd_take = s_axi_arvalid && !rvalid_r;
  wire [5:0] wr_idx = s_axi_awaddr[7:2];
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire wr_ok = wr_take && idx_known(wr_idx);
  wire [15:0] wr_val = strobe16(s_axi_wdata, s_axi_wstrb);
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Register write selects
  wire wr_mder = wr_ok && (wr_idx == IDX_MBX_DIR_EN);
  wire wr_tcr = wr_ok && (wr_idx == IDX_TX_CTRL);
  wire wr_rcr = wr_ok && (wr_idx == IDX_RX_CTRL);
  wire wr_mcr = wr_ok && (wr_idx == IDX_MASTER_CTRL);
  wire wr_ifr = wr_ok && (wr_idx == IDX_INT_FLAG);
  wire wr_imr = wr_ok && (wr_idx == IDX_INT_MASK);
  wire rd_ifr = rd_take && (rd_idx == IDX_INT_FLAG);

  // Counter level decode
  logic lvl_warn;
  logic lvl_passive;
  logic lvl_bus_off;
  err_level_eval u_levels (
    .tx_count_i(tec_r),
    .rx_count_i(rec_r),
    .warn_o(lvl_warn),
    .passive_o(lvl_passive),
    .bus_off_o(lvl_bus_off)
  );

  // Recessive run for automatic bus-on
  wire in_bus_off = (state_r == ST_BUS_OFF);
  wire auto_on = mcr_r[MCR_AUTO_BUS_ON];
  logic run_done;
  recessive_run_counter u_run (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .arm_i(in_bus_off && auto_on),
    .bit_tick_i(bit_tick_i),
    .recessive_i(rx_sync_r),
    .done_o(run_done)
  );

  // Bus-off exit: recessive run or software clearing the request
  wire sw_recover = in_bus_off && wr_mcr && s_axi_wstrb[1] &&
                    !s_axi_wdata[MCR_CHANGE_CFG] && mcr_r[MCR_CHANGE_CFG];
  wire recover = (in_bus_off && auto_on && run_done) || sw_recover;
  wire bus_off_entry = !in_bus_off && lvl_bus_off;

  // Fault confinement state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ACTIVE, ST_PASSIVE: begin
        if (lvl_bus_off) state_nxt = ST_BUS_OFF;
        else if (lvl_passive) state_nxt = ST_PASSIVE;
        else state_nxt = ST_ACTIVE;
      end
      ST_BUS_OFF: begin
        if (recover) state_nxt = ST_ACTIVE;
      end
      default: state_nxt = ST_BUS_OFF;
    endcase
  end

  // Error events are ignored while disconnected
  wire live = !in_bus_off;
  wire tx_ev = tx_done_i && live && mbx_active_o[tx_mbx_i < 3'h6 ? tx_mbx_i : 3'h0]
               && (tx_mbx_i < 3'h6);
  wire rx_ev = rx_done_i && live && mbx_active_o[rx_mbx_i < 3'h6 ? rx_mbx_i : 3'h0]
               && (rx_mbx_i < 3'h6);
  wire [5:0] tx_hot = tx_ev ? mbx_hot(tx_mbx_i) : 6'h00;
  wire [5:0] rx_hot = rx_ev ? mbx_hot(rx_mbx_i) : 6'h00;

  // Error counters
  assign tec_nxt = recover ? 9'h000 :
                   !live ? tec_r :
                   tx_err_i ? tec_r + TX_ERR_STEP :
                   (tx_ev && tec_r != 9'h000) ? tec_r - 9'h001 : tec_r;
  assign rec_nxt = recover ? 8'h00 :
                   !live ? rec_r :
                   (rx_err_i && rec_r != RX_ERR_MAX) ? rec_r + 8'h01 :
                   (rx_ev && rec_r != 8'h00) ? rec_r - 8'h01 : rec_r;

  // Master control, bus-off without auto bus-on forces the change configuration request
  wire [15:0] mcr_written = wr_mcr ? {wr_val[15:8] | (s_axi_wstrb[1] ? 8'h00 : mcr_r[15:8]),
                                      wr_val[7:0] | (s_axi_wstrb[0] ? 8'h00 : mcr_r[7:0])}
                                   : mcr_r;
  always_comb begin
    mcr_nxt = mcr_written;
    if (bus_off_entry && !auto_on) mcr_nxt[MCR_CHANGE_CFG] = 1'b1;
  end

  // Transmit requests, completion beats a new request; acknowledges and receive pending bits, set beats clear
  wire [5:0] trs_set = (wr_tcr && s_axi_wstrb[0]) ? wr_val[5:0] : 6'h00;
  wire [5:0] ack_clr = (wr_tcr && s_axi_wstrb[1]) ? wr_val[TCR_ACK_BASE +: 6] : 6'h00;
  wire [5:0] rmp_clr = (wr_rcr && s_axi_wstrb[0]) ? wr_val[5:0] : 6'h00;
  assign trs_nxt = (trs_r | trs_set) & ~tx_hot;
  assign ack_nxt = tx_hot | (ack_r & ~ack_clr);
  assign rmp_nxt = rx_hot | (rmp_r & ~rmp_clr);

  // Interrupt flags: set by events, cleared by read or by writing one
  wire warn_rise = lvl_warn && !warn_r && live;
  wire passive_rise = lvl_passive && !passive_r && live;
  logic [15:0] ifr_set;
  logic [15:0] ifr_clr;
  // Flags placed by field position; a read of the register clears all of them
  always_comb begin
    ifr_set = 16'h0000;
    ifr_set[IFR_WARN] = warn_rise;
    ifr_set[IFR_PASSIVE] = passive_rise;
    ifr_set[IFR_BUS_OFF] = bus_off_entry;
    ifr_set[IFR_MBX_BASE +: 6] = tx_hot | rx_hot;
    ifr_clr = rd_ifr ? 16'hffff : 16'h0000;
    if (wr_ifr) ifr_clr = ifr_clr | wr_val;
    ifr_clr[IFR_MBX_BASE +: 6] = ifr_clr[IFR_MBX_BASE +: 6] | ack_clr | rmp_clr;
  end
  // Set beats clear when both land in one cycle, so no event is lost
  assign ifr_nxt = ifr_set | (ifr_r & ~ifr_clr);

  // Status views, live error status built by field position
  logic [15:0] esr_view;
  logic [31:0] cec_view;
  always_comb begin
    esr_view = 16'h0000;
    esr_view[ESR_WARN] = lvl_warn && live;
    esr_view[ESR_PASSIVE] = state_r == ST_PASSIVE;
    esr_view[ESR_BUS_OFF] = in_bus_off;
  end
  // Receive counter in the low byte, transmit counter above it
  always_comb begin
    cec_view = 32'h00000000;
    cec_view[7:0] = rec_r;
    cec_view[CEC_TX_BASE +: 9] = tec_r;
  end
  wire [31:0] rd_mux =
    (rd_idx == IDX_MBX_DIR_EN) ? {24'h000000, mder_r} :
    (rd_idx == IDX_TX_CTRL) ? {18'h00000, ack_r, 2'b00, trs_r} :
    (rd_idx == IDX_RX_CTRL) ? {26'h0000000, rmp_r} :
    (rd_idx == IDX_MASTER_CTRL) ? {16'h0000, mcr_r} :
    (rd_idx == IDX_ERR_STATUS) ? {16'h0000, esr_view} :
    (rd_idx == IDX_ERR_COUNT) ? cec_view :
    (rd_idx == IDX_INT_FLAG) ? {16'h0000, ifr_r} :
    (rd_idx == IDX_INT_MASK) ? {16'h0000, imr_r} : 32'h00000000;

  // Outputs towards the protocol engine
  assign bus_on_o = live;
  assign mbx_active_o = mder_r[5:0] & {6{live}};
  assign tx_req_o = trs_r & mbx_active_o;
  assign mbx_dir_o = mder_r[7:6];
  assign data_lock_o = mcr_r[MCR_CHANGE_DATA];
  assign byte_order_o = mcr_r[MCR_BYTE_ORDER];
  assign err_state_o = state_r;
  assign irq_o = |(ifr_r & imr_r);

  // Fault state and counters
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_ACTIVE;
      tec_r <= 9'h000;
      rec_r <= 8'h00;
      warn_r <= 1'b0;
      passive_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tec_r <= tec_nxt;
      rec_r <= rec_nxt;
      warn_r <= lvl_warn;
      passive_r <= lvl_passive;
    end
  end

  // Control and flag registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mcr_r <= MCR_RESET;
      mder_r <= MDER_RESET;
      imr_r <= IMR_RESET;
      trs_r <= 6'h00;
      ack_r <= 6'h00;
      rmp_r <= 6'h00;
      ifr_r <= 16'h0000;
    end else begin
      mcr_r <= mcr_nxt;
      if (wr_mder && s_axi_wstrb[0]) mder_r <= wr_val[7:0];
      if (wr_imr) imr_r <= wr_val;
      trs_r <= trs_nxt;
      ack_r <= ack_nxt;
      rmp_r <= rmp_nxt;
      ifr_r <= ifr_nxt;
    end
  end

  // AXI write response
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_take) begin
      bvalid_r <= 1'b1;
      bresp_r <= idx_known(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // AXI read data
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= idx_known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule : can_fault_mbox

// ==== design/can_fc_pkg.sv ====
// Constants shared by the fault-confinement and mailbox flag logic
package can_fc_pkg;
  // Register indexes, byte address is four times the index
  localparam logic [5:0] IDX_MBX_DIR_EN = 6'h00;
  localparam logic [5:0] IDX_TX_CTRL = 6'h01;
  localparam logic [5:0] IDX_RX_CTRL = 6'h02;
  localparam logic [5:0] IDX_MASTER_CTRL = 6'h03;
  localparam logic [5:0] IDX_ERR_STATUS = 6'h06;
  localparam logic [5:0] IDX_ERR_COUNT = 6'h08;
  localparam logic [5:0] IDX_INT_FLAG = 6'h09;
  localparam logic [5:0] IDX_INT_MASK = 6'h0a;
  // Field positions
  localparam int MCR_AUTO_BUS_ON = 7;
  localparam int MCR_CHANGE_DATA = 8;
  localparam int MCR_BYTE_ORDER = 10;
  localparam int MCR_CHANGE_CFG = 12;
  localparam int IFR_WARN = 0;
  localparam int IFR_PASSIVE = 1;
  localparam int IFR_BUS_OFF = 2;
  localparam int IFR_MBX_BASE = 8;
  localparam int TCR_ACK_BASE = 8;
  localparam int ESR_WARN = 0;
  localparam int ESR_PASSIVE = 1;
  localparam int ESR_BUS_OFF = 2;
  localparam int CEC_TX_BASE = 8;
  // Reset values
  localparam logic [15:0] MCR_RESET = 16'h0000;
  localparam logic [7:0] MDER_RESET = 8'h00;
  localparam logic [15:0] IMR_RESET = 16'h0000;
  // Error counter levels and steps
  localparam logic [8:0] WARN_LEVEL = 9'h060;
  localparam logic [8:0] PASSIVE_LEVEL = 9'h07f;
  localparam logic [8:0] BUS_OFF_LEVEL = 9'h0ff;
  localparam logic [8:0] TX_ERR_STEP = 9'h008;
  localparam logic [7:0] RX_ERR_MAX = 8'hff;
  // Recessive bits that end bus-off with auto bus-on
  localparam logic [10:0] RECOVERY_BITS = 11'(128 * 11);
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_PASSIVE = 2'b01,
    ST_BUS_OFF = 2'b10
  } err_state_t;
endpackage : can_fc_pkg

// ==== design/err_level_eval.sv ====
// Decodes the error counters into warning, passive and bus-off levels
`timescale 1ns/1ps
module err_level_eval (
  input wire logic [8:0] tx_count_i, // Transmit error counter
  input wire logic [7:0] rx_count_i, // Receive error counter
  output logic warn_o, // Either counter at warning level
  output logic passive_o, // Either counter at passive level
  output logic bus_off_o // Transmit counter beyond 255
);
  import can_fc_pkg::*;
  // Threshold compares
  assign warn_o = (tx_count_i >= WARN_LEVEL) || ({1'b0, rx_count_i} >= WARN_LEVEL);
  assign passive_o = (tx_count_i >= PASSIVE_LEVEL) || ({1'b0, rx_count_i} >= PASSIVE_LEVEL);
  assign bus_off_o = tx_count_i > BUS_OFF_LEVEL;
endmodule : err_level_eval

// ==== design/recessive_run_counter.sv ====
// Counts consecutive recessive bits while bus-off recovery is armed
`timescale 1ns/1ps
module recessive_run_counter (
  input wire logic ref_clk_i, // Module clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic arm_i, // Count only while high
  input wire logic bit_tick_i, // One pulse per bit time
  input wire logic recessive_i, // Synchronised bus level, 1 is recessive
  output logic done_o // Run length reached
);
  import can_fc_pkg::*;
  logic [10:0] run_r;
  logic [10:0] run_nxt;
  // A dominant bit or disarm restarts the run
  assign run_nxt = !arm_i ? 11'h000 :
                   (bit_tick_i && !recessive_i) ? 11'h000 :
                   (bit_tick_i && !done_o) ? run_r + 11'h001 : run_r;
  assign done_o = run_r >= RECOVERY_BITS;
  // Run register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) run_r <= 11'h000;
    else run_r <= run_nxt;
  end
endmodule : recessive_run_counter

// ==== tb/bus_node_model.sv ====
// Far-side bus model: bit strobes and the receive line level
`timescale 1ns/1ps
module bus_node_model (
  input wire logic ref_clk_i, // Module clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic recessive_i, // Hold the bus recessive
  output logic bit_tick_o, // One pulse every second clock
  output logic can_rx_o // Bus level, 1 is recessive
);
  logic phase_r;
  logic toggle_r;
  // Bit strobe every second clock; a busy bus alternates its level
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r <= 1'b0;
      toggle_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
      if (phase_r) toggle_r <= ~toggle_r;
    end
  end
  assign bit_tick_o = phase_r;
  assign can_rx_o = recessive_i | toggle_r;
endmodule : bus_node_model

// ==== tb/can_fault_mbox_monitor.sv ====
// Concurrent checks on the fault confinement and register ports
`timescale 1ns/1ps
module can_fault_mbox_chk
  import can_fc_pkg::*;
(
  input wire logic ref_clk_i, // Module clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [5:0] tx_req_o, // Mailboxes asking to transmit
  input wire logic [5:0] mbx_active_o, // Mailboxes in traffic
  input wire logic bus_on_o, // Node may drive the bus
  input wire can_fc_pkg::err_state_t err_state_o // Fault confinement state
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Bus-off silences the node, every other state keeps it on the bus
  a_off_is_silent: assert property (
    err_state_o == ST_BUS_OFF |-> !bus_on_o && mbx_active_o == 6'h00)
    else $error("node active on bus while bus-off");
  a_on_unless_off: assert property (
    err_state_o != ST_BUS_OFF |-> bus_on_o)
    else $error("node off bus outside bus-off");
  a_req_needs_enable: assert property (
    (tx_req_o & ~mbx_active_o) == 6'h00)
    else $error("transmit request from idle mailbox");
  // Bus-off is entered only from passive and left only to active
  a_off_after_passive: assert property (
    $rose(err_state_o == ST_BUS_OFF) |-> $past(err_state_o) == ST_PASSIVE)
    else $error("bus-off entered without passive");
  a_recover_to_active: assert property (
    $past(err_state_o) == ST_BUS_OFF && err_state_o != ST_BUS_OFF
    |-> err_state_o == ST_ACTIVE)
    else $error("bus-off left to a state other than active");
  // Register bus answers and holds them until taken
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid)
    else $error("write response missing");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule : can_fault_mbox_chk

bind can_fault_mbox can_fault_mbox_chk u_chk (.ref_clk_i, .reset_n_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .tx_req_o, .mbx_active_o, .bus_on_o, .err_state_o);

// ==== tb/tb.sv ====
// Register-level testbench of the fault confinement and mailbox flags
`timescale 1ns/1ps
module tb;
  import can_fc_pkg::*;
  localparam logic [7:0] A_MDER = {IDX_MBX_DIR_EN, 2'b00};
  localparam logic [7:0] A_TCR = {IDX_TX_CTRL, 2'b00};
  localparam logic [7:0] A_RCR = {IDX_RX_CTRL, 2'b00};
  localparam logic [7:0] A_MCR = {IDX_MASTER_CTRL, 2'b00};
  localparam logic [7:0] A_ESR = {IDX_ERR_STATUS, 2'b00};
  localparam logic [7:0] A_CEC = {IDX_ERR_COUNT, 2'b00};
  localparam logic [7:0] A_IFR = {IDX_INT_FLAG, 2'b00};
  localparam logic [7:0] A_IMR = {IDX_INT_MASK, 2'b00};
  logic ref_clk_i, reset_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp, mbx_dir_o;
  logic can_rx_i, bit_tick_i, tx_err_i, rx_err_i, tx_done_i, rx_done_i, recessive;
  logic [2:0] tx_mbx_i, rx_mbx_i;
  logic [5:0] tx_req_o, mbx_active_o;
  logic data_lock_o, byte_order_o, bus_on_o, irq_o;
  err_state_t err_state_o;
  int n_errors = 0;
  int tests_run = 0;

  can_fault_mbox u_dut (.ref_clk_i, .reset_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .can_rx_i, .bit_tick_i, .tx_err_i,
    .rx_err_i, .tx_done_i, .tx_mbx_i, .rx_done_i, .rx_mbx_i, .tx_req_o, .mbx_active_o,
    .mbx_dir_o, .data_lock_o, .byte_order_o, .bus_on_o, .err_state_o, .irq_o);
  bus_node_model u_bus (.ref_clk_i, .reset_n_i, .recessive_i(recessive),
    .bit_tick_o(bit_tick_i), .can_rx_o(can_rx_i));

  // Clock at 40 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write: address, data and response ready offered together, each held until taken
  task axi_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge ref_clk_i); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    @(posedge ref_clk_i);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge ref_clk_i); while (s_axi_bvalid !== 1'b1);
    @(posedge ref_clk_i);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // Read: response taken at the edge where rvalid and rready meet
  task axi_rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk_i); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk_i); while (s_axi_rvalid !== 1'b1);
    @(posedge ref_clk_i);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a);
    chk(rd_data & m, e);
  endtask : rdc

  // Event pulses: sel is tx_err, rx_err, tx_done, rx_done
  task pulse(input logic [3:0] sel, input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      {tx_err_i, rx_err_i, tx_done_i, rx_done_i} <= sel;
      tx_mbx_i <= m;
      rx_mbx_i <= m;
      @(posedge ref_clk_i);
      {tx_err_i, rx_err_i, tx_done_i, rx_done_i} <= 4'h0;
    end
    repeat (3) @(posedge ref_clk_i);
  endtask : pulse

  task tally_and_finish;
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    reset_n_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h3;
    {tx_err_i, rx_err_i, tx_done_i, rx_done_i, recessive, tx_mbx_i, rx_mbx_i} = 11'h000;
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rdc(A_MCR, 32'hffffffff, {16'h0000, MCR_RESET});
    chk({28'h0, err_state_o, bus_on_o, irq_o}, {28'h0, ST_ACTIVE, 2'b10});
    axi_wr(8'h10, 16'hffff);
    chk(wr_resp, RESP_SLVERR);
    axi_rd(8'h10);
    chk({rd_data[29:0], rd_resp}, {30'h0, RESP_SLVERR});
    axi_wr(A_MDER, 16'h00c9);
    chk(wr_resp, RESP_OKAY);
    chk({mbx_dir_o, mbx_active_o}, 8'hc9);
    axi_wr(A_TCR, 16'h000a);
    chk(tx_req_o, 6'h08);
    pulse(4'hc, 3'd0, 1);
    pulse(4'h2, 3'd1, 1);
    pulse(4'h2, 3'd3, 1);
    pulse(4'h1, 3'd0, 1);
    rdc(A_TCR, 32'h3f00, 32'h0800);
    rdc(A_RCR, 32'h003f, 32'h0001);
    rdc(A_CEC, 32'h1ffff, 32'h0700);
    chk(irq_o, 1'b0);
    axi_wr(A_IMR, 16'h0900);
    chk(irq_o, 1'b1);
    axi_wr(A_TCR, 16'h0000);
    rdc(A_TCR, 32'h3f00, 32'h0800);
    axi_wr(A_TCR, 16'h0800);
    rdc(A_TCR, 32'h3f00, 32'h0000);
    chk(irq_o, 1'b1);
    axi_wr(A_RCR, 16'h0001);
    rdc(A_RCR, 32'h003f, 32'h0000);
    chk(irq_o, 1'b0);
    axi_wr(A_MDER, 16'h00c0);
    chk(mbx_active_o, 6'h00);
    axi_wr(A_MCR, 16'h0100);
    chk(data_lock_o, 1'b1);
    axi_wr(A_MCR, 16'h0400);
    chk({data_lock_o, byte_order_o}, 2'b01);
    axi_wr(A_MDER, 16'h00c9);
    chk(mbx_active_o, 6'h09);
    // Transmit counter climbs from 7 in steps of 8
    pulse(4'h8, 3'd0, 11);
    rdc(A_ESR, 32'h7, 32'h0);
    pulse(4'h8, 3'd0, 1);
    rdc(A_ESR, 32'h7, 32'h1);
    chk(err_state_o, ST_ACTIVE);
    pulse(4'h8, 3'd0, 3);
    rdc(A_ESR, 32'h3, 32'h3);
    chk(err_state_o, ST_PASSIVE);
    pulse(4'h8, 3'd0, 16);
    chk(err_state_o, ST_PASSIVE);
    pulse(4'h8, 3'd0, 1);
    rdc(A_ESR, 32'h4, 32'h4);
    rdc(A_IFR, 32'h7, 32'h7);
    rdc(A_MCR, 32'hffff, 32'h1400);
    chk({bus_on_o, mbx_active_o, tx_req_o, err_state_o}, {13'h0, ST_BUS_OFF});
    pulse(4'h2, 3'd3, 1);
    rdc(A_TCR, 32'h3f00, 32'h0000);
    axi_wr(A_MCR, 16'h0400);
    chk(err_state_o, ST_ACTIVE);
    rdc(A_CEC, 32'h1ffff, 32'h0);
    // Automatic recovery needs an unbroken recessive run
    axi_wr(A_MCR, 16'h0080);
    pulse(4'h8, 3'd0, 32);
    rdc(A_MCR, 32'h1000, 32'h0);
    repeat (3000) @(posedge ref_clk_i);
    chk(err_state_o, ST_BUS_OFF);
    recessive <= 1'b1;
    repeat (2700) @(posedge ref_clk_i);
    chk(err_state_o, ST_BUS_OFF);
    repeat (200) @(posedge ref_clk_i);
    chk(err_state_o, ST_ACTIVE);
    tally_and_finish();
  end
endmodule : tb
